// ===== dcff_defines.svh
// Register offsets, field positions, reset values and timing counts for the flag FIFO
`ifndef DCFF_DEFINES_SVH
`define DCFF_DEFINES_SVH

`define DCFF_DATA_W 18
`define DCFF_DEPTH_DEF 64
`define DCFF_DEPTH_MIN 64
`define DCFF_DEPTH_MAX 4096

`define DCFF_OFF_CTRL 8'h00
`define DCFF_OFF_AE 8'h04
`define DCFF_OFF_AF 8'h08
`define DCFF_OFF_STATUS 8'h0c
`define DCFF_OFF_INTST 8'h10
`define DCFF_OFF_INTMSK 8'h14

`define DCFF_CTRL_SYNC_BIT 0
`define DCFF_CTRL_RETX_BIT 1
`define DCFF_INT_FULL_BIT 0
`define DCFF_INT_EMPTY_BIT 1
`define DCFF_INT_AE_BIT 2
`define DCFF_INT_AF_BIT 3
`define DCFF_INT_W 4

`define DCFF_SYNC_RST 1'b1
`define DCFF_AE_OFF_RST 8
`define DCFF_AF_OFF_RST 8
`define DCFF_INTMSK_RST 4'h0

`define DCFF_CLK_PERIOD_NS 10
`define DCFF_FULL_SKEW_NS 5
`define DCFF_EMPTY_SKEW_NS 5
`define DCFF_ALMOST_SKEW_NS 15
`define DCFF_RTR_NS 12
`define DCFF_RTR_CYC ((`DCFF_RTR_NS + `DCFF_CLK_PERIOD_NS - 1) / `DCFF_CLK_PERIOD_NS)
`define DCFF_RTR_W 4

`endif

// ===== dcff_pkg.sv
// Types shared by the flag FIFO
package dcff_pkg;
  typedef logic [17:0] dcff_word_t;
  typedef enum logic [1:0] {
    DCFF_HT_IDLE = 2'b00,
    DCFF_HT_BUSY = 2'b01,
    DCFF_HT_NONSEQ = 2'b10,
    DCFF_HT_SEQ = 2'b11
  } dcff_htrans_t;
endpackage

// ===== dcff_flag_fifo.sv
// Single-clock 18-bit FIFO with full, empty and almost flags, chain outputs, AHB-Lite registers
//
// What this block does
// R1: Read frees slot; full clears one edge later
// R2: Write into empty; empty clears one edge later
// R3: Clocks may run during reset
// R4: After reset data low if enabled, else off
// R5: First word follows empty deassertion cycle
// R6: First-read latency applies only leaving empty
// R7: Write-caused almost-empty change waits one edge
// R8: Almost-empty low when reading leaves n-1 words
// R9: Almost-full low when m-1 words short
// R10: Read-caused almost-full change waits one edge
// R11: Pulse write chain at last location write
// R12: Pulse read chain at last location read
// R13: Flags valid after retransmit recovery time
// R14: User clocks once more before trusting almost flags
// R15: Ignore writes when full, reads when empty
// R16: Chain outputs are one-cycle pulses
`timescale 1ns/1ps
`include "dcff_defines.svh"

module dcff_flag_fifo import dcff_pkg::*; #(
  parameter int DEPTH = `DCFF_DEPTH_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire dcff_word_t wrData,
  input wire logic rdEn,
  input wire logic oeN,
  output logic writeChainOut,
  output logic readChainOut,
  output logic fullFlagN,
  output logic emptyFlagN,
  output logic almostEmptyFlagN,
  output logic almostFullFlagN,
  output dcff_word_t rdData,
  output logic rdDataOe,
  output logic irq,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW:0] DEPTH_X = (PW + 1)'(DEPTH);
  localparam logic [`DCFF_RTR_W-1:0] RTR_CYC = `DCFF_RTR_W'(`DCFF_RTR_CYC);

  generate
    if (DEPTH < `DCFF_DEPTH_MIN || DEPTH > `DCFF_DEPTH_MAX || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("DEPTH must be a power of two from 64 to 4096");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][17:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW-1:0] rptrSeen;
    logic [PW-1:0] wptrSeen;
    logic fullN;
    logic emptyN;
    logic aeN;
    logic afN;
    logic [17:0] rdData;
    logic oe;
    logic wco;
    logic rco;
    logic syncSel;
    logic [PW-1:0] aeOff;
    logic [PW-1:0] afOff;
    logic [`DCFF_RTR_W-1:0] rtrCnt;
    logic [`DCFF_INT_W-1:0] intStat;
    logic [`DCFF_INT_W-1:0] intMask;
    logic irq;
    logic dphWr;
    logic [7:0] dphAddr;
    logic [31:0] hrdata;
    logic rdy;
  } dcff_state_t;

  dcff_state_t s_reg;
  dcff_state_t s_next;
  logic wrAcc;
  logic rdAcc;
  logic addrValid;
  logic [PW-1:0] wrCount;
  logic [PW-1:0] rdCount;
  logic [PW-1:0] trueCount;
  logic [`DCFF_INT_W-1:0] intEvent;
  logic [`DCFF_INT_W-1:0] intClear;

  // Almost-full: count leaves fewer than m free slots
  function automatic logic almostFull(input logic [PW-1:0] cnt, input logic [PW-1:0] off);
    return ({1'b0, cnt} + {1'b0, off}) > DEPTH_X;
  endfunction

  function automatic logic [31:0] regRead(input logic [7:0] a, input dcff_state_t st,
                                          input logic [PW-1:0] cnt);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `DCFF_OFF_CTRL: r[`DCFF_CTRL_SYNC_BIT] = st.syncSel;
      `DCFF_OFF_AE: r[PW-1:0] = st.aeOff;
      `DCFF_OFF_AF: r[PW-1:0] = st.afOff;
      `DCFF_OFF_STATUS: r = {{(24 - PW){1'b0}}, cnt, 4'h0, st.afN, st.aeN, st.emptyN, st.fullN};
      `DCFF_OFF_INTST: r[`DCFF_INT_W-1:0] = st.intStat;
      `DCFF_OFF_INTMSK: r[`DCFF_INT_W-1:0] = st.intMask;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb begin
    s_next = s_reg;
    intClear = '0;
    wrAcc = wrEn && s_reg.fullN; // R15
    rdAcc = rdEn && s_reg.emptyN && (s_reg.rtrCnt == '0); // R15
    addrValid = hsel && hready && (htrans == DCFF_HT_NONSEQ || htrans == DCFF_HT_SEQ);

    // Write port
    s_next.wco = 1'b0;
    if (wrAcc) begin
      s_next.mem[s_reg.wptr[AW-1:0]] = wrData;
      s_next.wptr = s_reg.wptr + 1'b1;
      s_next.wco = (s_reg.wptr[AW-1:0] == AW'(DEPTH - 1)); // R11 R16
    end

    // Read port; data lands the cycle after the accepted read
    s_next.rco = 1'b0;
    if (rdAcc) begin
      s_next.rdData = s_reg.mem[s_reg.rptr[AW-1:0]]; // R5 R6
      s_next.rptr = s_reg.rptr + 1'b1;
      s_next.rco = (s_reg.rptr[AW-1:0] == AW'(DEPTH - 1)); // R12 R16
    end
    if (s_reg.rtrCnt != '0) begin
      s_next.rtrCnt = s_reg.rtrCnt - 1'b1; // R13
    end
    s_next.oe = !oeN; // R4

    // Register bus data phase
    if (s_reg.dphWr) begin
      case (s_reg.dphAddr)
        `DCFF_OFF_CTRL: begin
          s_next.syncSel = hwdata[`DCFF_CTRL_SYNC_BIT];
          if (hwdata[`DCFF_CTRL_RETX_BIT]) begin
            s_next.rptr = '0; // R13
            s_next.rtrCnt = RTR_CYC; // R13
          end
        end
        `DCFF_OFF_AE: s_next.aeOff = hwdata[PW-1:0];
        `DCFF_OFF_AF: s_next.afOff = hwdata[PW-1:0];
        `DCFF_OFF_INTST: intClear = hwdata[`DCFF_INT_W-1:0];
        `DCFF_OFF_INTMSK: s_next.intMask = hwdata[`DCFF_INT_W-1:0];
        default: ;
      endcase
    end

    // Each side sees the other's pointer one edge late
    s_next.rptrSeen = s_reg.rptr; // R1 R10
    s_next.wptrSeen = s_reg.wptr; // R2 R7
    wrCount = s_next.wptr - s_next.rptrSeen;
    rdCount = s_next.wptrSeen - s_next.rptr;
    trueCount = s_next.wptr - s_next.rptr;
    s_next.fullN = (wrCount != PW'(DEPTH)); // R1
    s_next.emptyN = (rdCount != '0); // R2 R6
    if (s_next.syncSel) begin
      s_next.aeN = !(rdCount < s_next.aeOff); // R7 R8
      s_next.afN = !almostFull(wrCount, s_next.afOff); // R9 R10
    end else begin
      s_next.aeN = !(trueCount < s_next.aeOff);
      s_next.afN = !almostFull(trueCount, s_next.afOff);
    end

    // Sticky events, set wins over clear
    intEvent = '0;
    intEvent[`DCFF_INT_FULL_BIT] = s_reg.fullN && !s_next.fullN;
    intEvent[`DCFF_INT_EMPTY_BIT] = s_reg.emptyN && !s_next.emptyN;
    intEvent[`DCFF_INT_AE_BIT] = s_reg.aeN && !s_next.aeN;
    intEvent[`DCFF_INT_AF_BIT] = s_reg.afN && !s_next.afN;
    s_next.intStat = (s_reg.intStat & ~intClear) | intEvent;
    s_next.irq = |(s_next.intStat & s_next.intMask);

    // Register bus address phase
    s_next.rdy = 1'b1;
    s_next.dphWr = addrValid && hwrite;
    if (addrValid) begin
      s_next.dphAddr = {haddr[7:2], 2'b00};
      if (!hwrite) begin
        s_next.hrdata = regRead({haddr[7:2], 2'b00}, s_reg, s_reg.wptr - s_reg.rptr);
      end
    end
  end

  // Clocks may keep running in reset; every flop takes constants only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0; // R3
      s_reg.fullN <= 1'b1;
      s_reg.emptyN <= 1'b0;
      s_reg.aeN <= 1'b0;
      s_reg.afN <= 1'b1;
      s_reg.syncSel <= `DCFF_SYNC_RST;
      s_reg.aeOff <= PW'(`DCFF_AE_OFF_RST);
      s_reg.afOff <= PW'(`DCFF_AF_OFF_RST);
      s_reg.intMask <= `DCFF_INTMSK_RST;
      s_reg.rdy <= 1'b1;
    end else if (clkEn) begin
      s_reg <= s_next;
    end
  end

  assign writeChainOut = s_reg.wco;
  assign readChainOut = s_reg.rco;
  assign fullFlagN = s_reg.fullN;
  assign emptyFlagN = s_reg.emptyN;
  assign almostEmptyFlagN = s_reg.aeN;
  assign almostFullFlagN = s_reg.afN;
  assign rdData = s_reg.rdData; // R4
  assign rdDataOe = s_reg.oe; // R4
  assign irq = s_reg.irq;
  assign hreadyout = s_reg.rdy;
  assign hrdata = s_reg.hrdata;
  assign hresp = 1'b0;

endmodule

// ===== dcff_flag_fifo_properties.sv
// Port-level checks on the flag FIFO
`timescale 1ns/1ps
module dcff_flag_fifo_checker import dcff_pkg::*; (
  input logic ref_clk,
  input logic rst,
  input logic wrEn,
  input logic rdEn,
  input logic oeN,
  input logic writeChainOut,
  input logic readChainOut,
  input logic fullFlagN,
  input logic emptyFlagN,
  input dcff_word_t rdData,
  input logic rdDataOe,
  input logic irq,
  input logic hreadyout,
  input logic hresp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wchain_pulse_a: assert property (writeChainOut |=> !writeChainOut)
    else $error("write chain pulse too long");
  rchain_pulse_a: assert property (readChainOut |=> !readChainOut)
    else $error("read chain pulse too long");
  wchain_cause_a: assert property (writeChainOut |-> $past(wrEn && fullFlagN))
    else $error("write chain without write");
  rchain_cause_a: assert property (readChainOut |-> $past(rdEn && emptyFlagN))
    else $error("read chain without read");
  empty_lag_a: assert property (!emptyFlagN && wrEn && !$past(wrEn) |=>
    !emptyFlagN ##1 emptyFlagN) else $error("empty flag timing");
  full_lag_a: assert property (!fullFlagN && rdEn && !$past(rdEn) |=>
    !fullFlagN ##1 fullFlagN) else $error("full flag timing");
  drop_read_a: assert property (!emptyFlagN && rdEn |=> $stable(rdData))
    else $error("read taken while empty");
  oe_follow_a: assert property (rdDataOe |-> $past(oeN) == 1'b0)
    else $error("output drive without enable");
  ahb_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  cover property (writeChainOut);
  cover property (readChainOut);
  cover property (irq);
endmodule
bind dcff_flag_fifo dcff_flag_fifo_checker chk (.*);

// ===== dcff_stream_peer.sv
// Producer and consumer logic on the FIFO ports
`timescale 1ns/1ps
module dcff_stream_peer import dcff_pkg::*; (
  input logic ref_clk,
  input logic fullFlagN,
  input logic emptyFlagN,
  input int wantWr,
  input int wantRd,
  output logic wrEn,
  output dcff_word_t wrData,
  output logic rdEn
);
  int nw = 0;
  int nr = 0;
  // Requests held until taken, also against a full or empty FIFO
  assign wrEn = nw < wantWr;
  assign rdEn = nr < wantRd;
  // Idle data shows the inverse word
  assign wrData = wrEn ? dcff_word_t'(18'h155 + nw) : ~dcff_word_t'(18'h155 + nw);
  always @(posedge ref_clk) begin
    if (wrEn && fullFlagN)
      nw <= nw + 1;
    if (rdEn && emptyFlagN)
      nr <= nr + 1;
  end
endmodule

// ===== test_dcff_flag_fifo.sv
// Self-checking bench for the flag FIFO
`timescale 1ns/1ps
`include "dcff_defines.svh"
module test_dcff_flag_fifo import dcff_pkg::*; ;
  logic ref_clk = 0, rst = 1, oeN = 1, hsel = 0, hwrite = 0, rdAcc = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic wrEn, rdEn, writeChainOut, readChainOut, fullFlagN, emptyFlagN, hready;
  logic almostEmptyFlagN, almostFullFlagN, rdDataOe, irq, hreadyout, hresp;
  dcff_word_t wrData, rdData, expW = 18'h155;
  int wantWr = 0, wantRd = 0, errors = 0, totalChecks = 0, sawW = 0, sawR = 0;
  assign hready = hreadyout;
  dcff_flag_fifo #(.DEPTH(64)) uut (.*, .clkEn(1'b1), .hsize(3'h2));
  dcff_stream_peer peer (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task chk(string n, logic [31:0] s, e);
    totalChecks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wt(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task ahb(logic w, logic [31:0] a, d);
    @(posedge ref_clk);
    hsel <= 1;
    htrans <= DCFF_HT_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= DCFF_HT_IDLE;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Every accepted read must deliver the next word in order
  always @(posedge ref_clk) begin
    rdAcc <= rdEn && emptyFlagN && !rst;
    if (rdAcc) begin
      chk("rdData", 32'(rdData), 32'(expW));
      expW = expW + 1;
    end
    if (writeChainOut)
      sawW++;
    if (readChainOut)
      sawR++;
  end
  task t_reset;
    chk("empty", 32'(emptyFlagN), 32'h0);
    chk("oe", 32'(rdDataOe), 32'h0);
    oeN <= 0;
    wt(2);
    chk("oe", 32'(rdDataOe), 32'h1);
    chk("data", 32'(rdData), 32'h0);
    ahb(0, `DCFF_OFF_AE, 0);
    chk("aeOff", rd, 32'h8);
    ahb(0, 32'h40, 0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
  endtask
  task t_fill;
    ahb(1, `DCFF_OFF_INTMSK, 32'h1);
    wantWr <= 56;
    wt(70);
    chk("afull", 32'(almostFullFlagN), 32'h1);
    wantWr <= 57;
    wt(5);
    chk("afull", 32'(almostFullFlagN), 32'h0);
    wantWr <= 66;
    wt(20);
    wantWr <= 64;
    chk("full", 32'(fullFlagN), 32'h0);
    chk("wchain", sawW, 1);
    chk("irq", 32'(irq), 32'h1);
    ahb(0, `DCFF_OFF_STATUS, 0);
    chk("count", 32'(rd[14:8]), 32'h40);
    ahb(1, `DCFF_OFF_INTST, 32'h1);
    wt(2);
    chk("irq", 32'(irq), 32'h0);
    $display("test fill done");
  endtask
  task t_drain;
    wantRd <= 56;
    wt(70);
    chk("aempty", 32'(almostEmptyFlagN), 32'h1);
    chk("afull", 32'(almostFullFlagN), 32'h1);
    wantRd <= 57;
    wt(5);
    chk("aempty", 32'(almostEmptyFlagN), 32'h0);
    wantRd <= 64;
    wt(15);
    chk("empty", 32'(emptyFlagN), 32'h0);
    chk("rchain", sawR, 1);
    chk("irq", 32'(irq), 32'h0);
    $display("test drain done");
  endtask
  task t_pass;
    wantWr <= 65;
    wantRd <= 65;
    wt(10);
    chk("next", 32'(expW), 32'h196);
    chk("empty", 32'(emptyFlagN), 32'h0);
    $display("test first word done");
  endtask
  // Reset in mid-run, then replay four words after a retransmit
  task t_retx;
    rst <= 1;
    wt(2);
    rst <= 0;
    wt(2);
    chk("empty", 32'(emptyFlagN), 32'h0);
    chk("data", 32'(rdData), 32'h0);
    wantWr <= 69;
    wantRd <= 69;
    wt(12);
    chk("next", 32'(expW), 32'h19a);
    ahb(1, `DCFF_OFF_CTRL, 32'h3);
    expW = 18'h196;
    wt(3);
    chk("empty", 32'(emptyFlagN), 32'h1);
    chk("aempty", 32'(almostEmptyFlagN), 32'h0);
    wantRd <= 73;
    wt(10);
    chk("next", 32'(expW), 32'h19a);
    chk("empty", 32'(emptyFlagN), 32'h0);
    $display("test retransmit done");
  endtask
  task finish_test;
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    wt(2);
    t_reset;
    t_fill;
    t_drain;
    t_pass;
    t_retx;
    finish_test;
  end
endmodule
